/* include/loop_iface_pkg.sv */
// Purpose: Shared constants for the serial-loop interface init and bus pins.
// Assumes: Registers sit at their printed indices 0 to 3 on a byte port.
// Notes:   Bit times count 0 to 55 within one calculator word.
package loop_iface_pkg;

  // Register port geometry.
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register indices.
  localparam logic [2:0] REG_STATUS = 3'h0;
  localparam logic [2:0] REG_FLAGS  = 3'h1;
  localparam logic [2:0] REG_DATA   = 3'h2;
  localparam logic [2:0] PARALLEL_POLL_REG = 3'h3;

  // Field positions.
  localparam int MCL_BIT      = 0;
  localparam int SYSCTL_BIT   = 7;
  localparam int FLAG_OUTPUT_ENABLE_BIT   = 0;
  localparam int OSC_DISABLE_BIT_BIT   = 7;
  localparam int AUTOIDLE_BIT = 6;
  localparam int PP_LOW_W     = 6;
  localparam int CTRL_LSB     = 5;
  localparam int CTRL_W       = 3;

  // Flag order in register 1 read and flag digits 6 to 10.
  localparam int NFLAG       = 5;
  localparam int F_IFC       = 4;
  localparam int F_SRQ       = 3;
  localparam int F_FWAIT     = 2;
  localparam int F_FMISM     = 1;
  localparam int F_OREG_FREE = 0;

  // Calculator word timing.
  localparam int WORD_BITS = 56;
  localparam logic [5:0] BIT_LAST     = 6'h37;
  localparam logic [5:0] INSN_FIRST   = 6'h2c;
  localparam logic [5:0] INSN_LAST    = 6'h35;
  localparam logic [5:0] FLAG_FIRST   = 6'h18;
  localparam logic [5:0] FLAG_LAST    = 6'h2b;
  localparam int INSN_W = 10;

  // Instruction codes of the register-read sequence.
  localparam logic [9:0] PERI_MASK = 10'h23f;
  localparam logic [9:0] PERI_CODE = 10'h224;
  localparam logic [9:0] READ_CODE = 10'h03a;
  localparam logic [9:0] RET_CODE  = 10'h003;
  localparam int SEL_LSB = 6;

  // Initialization states.
  typedef enum logic [1:0] {
    INIT_RESET  = 2'b00,
    INIT_OSC_ON = 2'b01,
    INIT_RUN    = 2'b11
  } init_state_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_PERI = 2'b01,
    SEQ_READ = 2'b11,
    SEQ_RET  = 2'b10
  } seq_state_t;

endpackage

/* src/loop_iface_init.sv */
// Purpose: Init sequencing, flags and calculator bus pins of a loop interface.
// Assumes: Bus clocks and lines are sampled synchronously to clk.
// Notes:   Pin drivers are registered; data and flag enables drop at each phase one fall.
// Operation
// - Full reset when power level low and sync low, or low with auto idle off.
// - Full reset returns bus bit timing and instruction decode to start.
// - Full reset clears the oscillator run enable.
// - Oscillator run enable cleared forces master clear to one.
// - Master clear clears four flags and sets the output-register-free flag.
// - Master clear resets the flag output enable bit.
// - Master clear loads the system controller bit from the strap.
// - Master clear resets the request-to-send latch.
// - Master clear puts driver and acceptor machines in their idle states.
// - Normal run only by writing zero to master clear with oscillator on.
// - Data line carries 56-bit words least significant bit first.
// - Data line driven only in words after second and third read words.
// - Data line released otherwise and always during phase two.
// - Instruction bits sampled during bit times 44 through 53.
// - Light sleep drives instruction line high when any wake flag is set.
// - Instruction line released whenever the power level is high.
// - Flag digits 6-10 drive low three bit times, then high, when enabled and their flag is set.
// - Flag line released otherwise and always during phase two.
// - External test clock may replace the tank oscillator.
// - Strap low makes the chip system controller.
// - Writing one to oscillator disable with master clear set stops it.
// - Master clear leaves the auto idle bit; it powers up low.
// - Flag digits carry clear, request, waiting, mismatch, output-free.
`timescale 1ns/1ps
module loop_iface_init
  import loop_iface_pkg::*;
(
  // Clock and reset.
  input  wire logic                               clk,
  input  wire logic                               rstn,
  // Register port.
  input  wire logic [loop_iface_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [loop_iface_pkg::DATA_W-1:0]  regWdata,
  input  wire logic                               regWr,
  input  wire logic                               regRd,
  output logic      [loop_iface_pkg::DATA_W-1:0]  regRdata,
  // Calculator bus.
  input  wire logic                               phi1,
  input  wire logic                               phi2,
  input  wire logic                               syncLine,
  input  wire logic                               powerOnLevel,
  input  wire logic                               dataIn,
  output logic                                    dataOut,
  output logic                                    dataOe,
  input  wire logic                               instructionLineIn,
  output logic                                    instructionLineOut,
  output logic                                    instructionLineOe,
  output logic                                    flagReturnOut,
  output logic                                    flagReturnOe,
  // Straps and loop clock sources.
  input  wire logic                               controllerStrap,
  input  wire logic                               useTestClock,
  input  wire logic                               testClockInput,
  input  wire logic                               tankIn,
  output logic                                    loopClock,
  // Loop-side events and state.
  input  wire logic                               ifcEvent,
  input  wire logic                               srqEvent,
  input  wire logic                               frameWaitEvent,
  input  wire logic                               frameMismatchEvent,
  input  wire logic                               outRegTaken,
  input  wire logic                               rtsEvent,
  output logic                                    oscRunEnable,
  output logic                                    masterClear,
  output logic                                    requestToSend,
  output logic                                    driverIdle,
  output logic                                    acceptorIdle
);
  import loop_iface_pkg::*;

  init_state_t              init_r;
  seq_state_t               seq_r;
  logic                     fullReset;
  logic                     master_clear_bit;
  logic [NFLAG-1:0]         flags_r;
  logic [NFLAG-1:0]         setEvt;
  logic                     flagEnb_r;
  logic [CTRL_W-1:0]        ctrl_r;
  logic                     sysCtl_r;
  logic [DATA_W-1:0]        outData_r;
  logic                     autoIdle_r;
  logic [PP_LOW_W-1:0]      ppLow_r;
  logic                     phi1Last_r;
  logic                     phi1Fall;
  logic                     syncLast_r;
  logic [5:0]               bitCnt_r;
  logic [INSN_W-1:0]        insn_r;
  logic [INSN_W-1:0]        insnDone;
  logic [ADDR_W-1:0]        sel_r;
  logic                     driveNext_r;
  logic                     driveWord_r;
  logic [WORD_BITS-1:0]     shift_r;
  logic [DATA_W-1:0]        selData;
  logic [1:0]               digitPos;
  logic                     inFlagDigits;
  logic [2:0]               flagIdx;
  logic                     wrR0;
  logic                     wrR3;

  // Deep sleep, or light sleep without auto idle, fully resets the chip.
  assign fullReset = !powerOnLevel && (!syncLine || !autoIdle_r);
  assign master_clear_bit       = (init_r != INIT_RUN);
  assign wrR0      = regWr && (regAddr == REG_STATUS);
  assign wrR3      = regWr && (regAddr == PARALLEL_POLL_REG);

  // Three-state sequence keeps the loop cleared until master clear is written zero with the oscillator running.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      init_r <= INIT_RESET;
    else if (fullReset)
      init_r <= INIT_RESET;
    else
      case (init_r)
        INIT_RESET:
          if (wrR3 && !regWdata[OSC_DISABLE_BIT_BIT])
            init_r <= INIT_OSC_ON;
        INIT_OSC_ON:
          if (wrR3 && regWdata[OSC_DISABLE_BIT_BIT])
            init_r <= INIT_RESET;
          else if (wrR0 && !regWdata[MCL_BIT])
            init_r <= INIT_RUN;
        INIT_RUN:
          if (wrR0 && regWdata[MCL_BIT])
            init_r <= INIT_OSC_ON;
        default:
          init_r <= INIT_RESET;
      endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      oscRunEnable <= 1'b0;
      masterClear  <= 1'b1;
    end
    else
    begin
      oscRunEnable <= !fullReset && (init_r != INIT_RESET);
      masterClear  <= master_clear_bit || fullReset;
    end
  end

  // Flags: master clear holds them, so here the clear beats an event.
  assign setEvt[F_IFC]   = ifcEvent;
  assign setEvt[F_SRQ]   = srqEvent;
  assign setEvt[F_FWAIT] = frameWaitEvent;
  assign setEvt[F_FMISM] = frameMismatchEvent;
  assign setEvt[F_OREG_FREE] = outRegTaken;

  generate
    for (genvar g = 1; g < NFLAG; g++)
    begin : g_flag
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          flags_r[g] <= 1'b0;
        else if (master_clear_bit)
          flags_r[g] <= 1'b0;
        else if (setEvt[g])
          flags_r[g] <= 1'b1;
      end
    end
  endgenerate

  // A new output byte takes the free flag; a send completing sets it.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      flags_r[F_OREG_FREE] <= 1'b1;
    else if (master_clear_bit || setEvt[F_OREG_FREE])
      flags_r[F_OREG_FREE] <= 1'b1;
    else if (regWr && (regAddr == REG_DATA))
      flags_r[F_OREG_FREE] <= 1'b0;
  end

  // Software-visible control bits.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flagEnb_r <= 1'b0;
      ctrl_r    <= '0;
      sysCtl_r  <= 1'b0;
      outData_r <= '0;
    end
    else
    begin
      if (master_clear_bit)
        flagEnb_r <= 1'b0;
      else if (regWr && (regAddr == REG_FLAGS))
        flagEnb_r <= regWdata[FLAG_OUTPUT_ENABLE_BIT];
      if (regWr && (regAddr == REG_FLAGS))
        ctrl_r <= regWdata[CTRL_LSB +: CTRL_W];
      // Strap is caught by the clock, never by the asynchronous reset.
      if (master_clear_bit)
        sysCtl_r <= !controllerStrap;
      if (regWr && (regAddr == REG_DATA))
        outData_r <= regWdata;
    end
  end

  // Auto idle survives master clear; it powers up low and changes only on register 3 writes.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      autoIdle_r <= 1'b0;
      ppLow_r    <= '0;
    end
    else if (wrR3)
    begin
      autoIdle_r <= regWdata[AUTOIDLE_BIT];
      ppLow_r    <= regWdata[PP_LOW_W-1:0];
    end
  end

  // Request latch and loop machine idle states.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      requestToSend <= 1'b0;
      driverIdle    <= 1'b1;
      acceptorIdle  <= 1'b1;
    end
    else if (master_clear_bit)
    begin
      requestToSend <= 1'b0;
      driverIdle    <= 1'b1;
      acceptorIdle  <= 1'b1;
    end
    else
    begin
      if (rtsEvent)
        requestToSend <= 1'b1;
      if (regWr && (regAddr == REG_DATA))
        driverIdle <= 1'b0;
      else if (outRegTaken)
        driverIdle <= 1'b1;
      if (frameWaitEvent)
        acceptorIdle <= 1'b0;
      else if (regRd && (regAddr == REG_DATA))
        acceptorIdle <= 1'b1;
    end
  end

  // Read data stand in the cycle after the read strobe only.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      regRdata <= '0;
    else if (!regRd)
      regRdata <= '0;
    else
      case (regAddr)
        REG_STATUS:
          regRdata <= {sysCtl_r, 6'h00, master_clear_bit};
        REG_FLAGS:
          regRdata <= {ctrl_r, flags_r};
        REG_DATA:
          regRdata <= outData_r;
        PARALLEL_POLL_REG:
          regRdata <= {!oscRunEnable, autoIdle_r, ppLow_r};
        default:
          regRdata <= '0;
      endcase
  end

  // Bit timing advances at each trailing edge of phase one.
  assign phi1Fall = phi1Last_r && !phi1;
  assign insnDone = {instructionLineIn, insn_r[INSN_W-1:1]};

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      phi1Last_r <= 1'b0;
    else
      phi1Last_r <= phi1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bitCnt_r   <= '0;
      syncLast_r <= 1'b0;
      insn_r     <= '0;
    end
    else if (fullReset)
    begin
      bitCnt_r   <= '0;
      syncLast_r <= 1'b0;
      insn_r     <= '0;
    end
    else if (phi1Fall)
    begin
      syncLast_r <= syncLine;
      if (syncLine && !syncLast_r)
        bitCnt_r <= INSN_FIRST + 6'h01;
      else if (bitCnt_r == BIT_LAST)
        bitCnt_r <= '0;
      else
        bitCnt_r <= bitCnt_r + 6'h01;
      if ((syncLine && !syncLast_r) ||
          (bitCnt_r >= INSN_FIRST && bitCnt_r <= INSN_LAST))
        insn_r <= insnDone;
    end
  end

  // Register-read sequence decode, checked as the last opcode bit lands.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      seq_r       <= SEQ_IDLE;
      sel_r       <= '0;
      driveNext_r <= 1'b0;
    end
    else if (fullReset)
    begin
      seq_r       <= SEQ_IDLE;
      driveNext_r <= 1'b0;
    end
    else if (phi1Fall && bitCnt_r == INSN_LAST)
    begin
      driveNext_r <= 1'b0;
      case (seq_r)
        SEQ_IDLE:
          if ((insnDone & PERI_MASK) == PERI_CODE)
          begin
            seq_r <= SEQ_PERI;
            sel_r <= insnDone[SEL_LSB +: ADDR_W];
          end
        SEQ_PERI:
          if (insnDone == READ_CODE)
          begin
            seq_r       <= SEQ_READ;
            driveNext_r <= 1'b1;
          end
          else
            seq_r <= SEQ_IDLE;
        SEQ_READ:
        begin
          seq_r       <= (insnDone == RET_CODE) ? SEQ_RET : SEQ_IDLE;
          driveNext_r <= (insnDone == RET_CODE);
        end
        SEQ_RET:
          seq_r <= SEQ_IDLE;
        default:
          seq_r <= SEQ_IDLE;
      endcase
    end
  end

  always_comb
  begin
    case (sel_r)
      REG_STATUS:        selData = {sysCtl_r, 6'h00, master_clear_bit};
      REG_FLAGS:         selData = {ctrl_r, flags_r};
      REG_DATA:          selData = outData_r;
      PARALLEL_POLL_REG: selData = {!oscRunEnable, autoIdle_r, ppLow_r};
      default:           selData = '0;
    endcase
  end

  // The selected byte goes out zero-filled to a whole word, LSB first.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      driveWord_r <= 1'b0;
      shift_r     <= '0;
    end
    else if (fullReset)
      driveWord_r <= 1'b0;
    else if (phi1Fall && bitCnt_r == BIT_LAST)
    begin
      driveWord_r <= driveNext_r;
      shift_r     <= {{(WORD_BITS-DATA_W){1'b0}}, selData};
    end
    else if (phi1Fall)
      shift_r <= {1'b0, shift_r[WORD_BITS-1:1]};
  end

  // Flag digits: bit 0-2 low, bit 3 high, clear flag first.
  assign inFlagDigits = (bitCnt_r >= FLAG_FIRST) && (bitCnt_r <= FLAG_LAST);
  assign digitPos     = bitCnt_r[1:0];
  assign flagIdx      = 3'(NFLAG - 1) - 3'((bitCnt_r - FLAG_FIRST) >> 2);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dataOut            <= 1'b0;
      dataOe             <= 1'b0;
      instructionLineOut <= 1'b0;
      instructionLineOe  <= 1'b0;
      flagReturnOut      <= 1'b0;
      flagReturnOe       <= 1'b0;
      loopClock          <= 1'b0;
    end
    else
    begin
      dataOut <= shift_r[0];
      // Dropping at the phase one fall clears phase two despite the flop.
      dataOe  <= driveWord_r && !phi2 && !phi1Fall && !fullReset;
      instructionLineOut <= 1'b1;
      instructionLineOe  <= !powerOnLevel && syncLine &&
                            (|flags_r[NFLAG-1:1]);
      flagReturnOut <= (digitPos == 2'h3);
      flagReturnOe  <= flagEnb_r && inFlagDigits && !phi2 &&
                       !phi1Fall && flags_r[flagIdx] && powerOnLevel;
      // Loop clock stops whenever the oscillator is disabled.
      loopClock <= oscRunEnable &&
                   (useTestClock ? testClockInput : tankIn);
    end
  end

  a_reset_stops_osc: assert property (
    @(posedge clk) disable iff (!rstn)
    fullReset |=> !oscRunEnable && masterClear)
    else $error("Oscillator still enabled under full reset.");

  a_osc_off_mcl: assert property (
    @(posedge clk) disable iff (!rstn)
    !oscRunEnable |-> masterClear)
    else $error("Master clear low while oscillator is off.");

  a_run_entry: assert property (
    @(posedge clk) disable iff (!rstn)
    (init_r == INIT_OSC_ON && wrR0 && !regWdata[MCL_BIT] && !fullReset
     && !(wrR3 && regWdata[OSC_DISABLE_BIT_BIT])) |=> ##1 !masterClear)
    else $error("Normal run not entered after clearing master clear.");

  a_mcl_flags: assert property (
    @(posedge clk) disable iff (!rstn)
    master_clear_bit ##1 master_clear_bit |-> flags_r == 5'h01)
    else $error("Flags not held by master clear.");

  a_osdis_stop: assert property (
    @(posedge clk) disable iff (!rstn)
    (init_r == INIT_OSC_ON && wrR3 && regWdata[OSC_DISABLE_BIT_BIT]) |=>
    ##1 !oscRunEnable)
    else $error("Oscillator disable write ignored.");

  a_data_phase2: assert property (
    @(posedge clk) disable iff (!rstn)
    $past(phi2) |-> !dataOe)
    else $error("Data line driven during phase two.");

  a_isa_release: assert property (
    @(posedge clk) disable iff (!rstn)
    $past(powerOnLevel) |-> !instructionLineOe)
    else $error("Instruction line driven with power level high.");

  a_flag_release: assert property (
    @(posedge clk) disable iff (!rstn)
    flagReturnOe |-> $past(flagEnb_r) && !$past(phi2) &&
    $past(bitCnt_r) >= FLAG_FIRST && $past(bitCnt_r) <= FLAG_LAST)
    else $error("Flag line driven outside flag digits.");

  a_strap_sc: assert property (
    @(posedge clk) disable iff (!rstn)
    master_clear_bit ##1 master_clear_bit |-> sysCtl_r == !$past(controllerStrap))
    else $error("System controller bit not loaded from strap.");

endmodule

/* testbench/cpu_bus_model.sv */
// Purpose: Calculator CPU side of the two-phase serial bus.
// Assumes: Eight clk cycles per bit time, 56 bit times per word.
// Notes:   Phases stop outside run mode, as in either sleep state.
`timescale 1ns/1ps
module cpu_bus_model (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rstn,
  // Bench control.
  input  wire logic [1:0]  mode,
  input  wire logic [9:0]  nextInsn,
  // Chip drivers.
  input  wire logic        dataOut,
  input  wire logic        dataOe,
  input  wire logic        isaOut,
  input  wire logic        isaOe,
  input  wire logic        flagOut,
  input  wire logic        flagOe,
  // Bus levels.
  output logic             phi1,
  output logic             phi2,
  output logic             syncLine,
  output logic             powerOnLevel,
  output logic             dataLine,
  output logic             isaLine,
  // Word results.
  output logic             wordDone,
  output logic [55:0]      dataWord,
  output logic [6:0]       dataBits,
  output logic [55:0]      flagOeWord,
  output logic [55:0]      flagValWord
);
  logic [2:0]  sub;
  logic [5:0]  bitNo;
  logic [9:0]  curInsn;
  logic [55:0] dataAcc;
  logic [6:0]  bitsAcc;
  logic        lastData;
  logic        lastIsa;
  logic        running;
  logic        insnTime;

  assign running      = (mode == 2'h0);
  assign insnTime     = (bitNo >= 6'h2c) && (bitNo <= 6'h35);
  assign powerOnLevel = running;
  assign syncLine     = running ? insnTime : (mode == 2'h1);
  assign phi1         = running && (sub == 3'h2 || sub == 3'h3);
  assign phi2         = running && (sub == 3'h5 || sub == 3'h6);
  // A released line shows the inverse of its last level, so a chip that
  // forgets to drive cannot pass on a stale value.
  assign dataLine = dataOe ? dataOut : ~lastData;
  assign isaLine  = isaOe ? isaOut :
                    (running && insnTime) ? curInsn[bitNo - 6'h2c] :
                    ~lastIsa;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sub      <= 3'h0;
      bitNo    <= 6'h0;
      curInsn  <= 10'h0;
      lastData <= 1'h0;
      lastIsa  <= 1'h0;
      wordDone <= 1'h0;
      bitsAcc  <= 7'h0;
    end
    else
    begin
      lastData <= dataLine;
      lastIsa  <= isaLine;
      wordDone <= 1'h0;
      if (!running)
      begin
        sub   <= 3'h0;
        bitNo <= 6'h0;
      end
      else
      begin
        sub <= sub + 3'h1;
        if (sub == 3'h7)
          bitNo <= (bitNo == 6'h37) ? 6'h0 : bitNo + 6'h1;
        if (sub == 3'h0 && bitNo == 6'h2b)
          curInsn <= nextInsn;
        if (sub == 3'h3)
        begin
          dataAcc[bitNo]     <= dataLine;
          bitsAcc            <= bitsAcc + {6'h0, dataOe};
          flagOeWord[bitNo]  <= flagOe;
          flagValWord[bitNo] <= flagOut;
          if (bitNo == 6'h37)
          begin
            wordDone <= 1'h1;
            dataWord <= {dataLine, dataAcc[54:0]};
            dataBits <= bitsAcc + {6'h0, dataOe};
            bitsAcc  <= 7'h0;
          end
        end
      end
    end
  end
endmodule

/* testbench/loop_iface_init_tb_top.sv */
// Purpose: Self-checking bench of the loop interface init and bus pins.
// Assumes: Test clock selected, tank pin held high.
// Notes:   A flag check after clear, then register rows, then bus, flag and sleep cases.
`timescale 1ns/1ps
module loop_iface_init_tb_top;
  import loop_iface_pkg::*;
  typedef struct packed {
    logic       wr;
    logic [2:0] a;
    logic [7:0] d;
    logic       osc;
    logic       master_clear_bit;
  } row_t;
  logic        clk, regWr = 1'h0, regRd = 1'h0, rstn = 1'h0;
  logic [2:0]  regAddr = 3'h0;
  logic [7:0]  regWdata = 8'h0, regRdata, rd;
  logic        ifcEvent = 1'h0, srqEvent = 1'h0, frameWaitEvent = 1'h0;
  logic        rtsEvent = 1'h0, controllerStrap = 1'h0;
  logic        testClockInput = 1'h0, useTestClock = 1'h1, tankIn = 1'h1;
  logic        frameMismatchEvent = 1'h0, outRegTaken = 1'h0;
  logic [1:0]  mode = 2'h0;
  logic [9:0]  nextInsn = 10'h0;
  logic        phi1, phi2, syncLine, powerOnLevel, dataIn, dataOut, dataOe;
  logic        instructionLineIn, instructionLineOut, instructionLineOe;
  logic        flagReturnOut, flagReturnOe, loopClock, oscRunEnable;
  logic        masterClear, requestToSend, driverIdle, acceptorIdle;
  logic        wordDone, prevPwr = 1'h0;
  logic [6:0]  dataBits;
  logic [55:0] dataWord, flagOeWord, flagValWord;
  int          n_fail = 0, total_checks = 0, n;
  // Read sequence for register 1: select, read, return, then idle words.
  logic [9:0]  seq [5] = '{10'h264, 10'h03a, 10'h003, 10'h000, 10'h000};
  row_t        rows [16] = '{
    '{1'h0, 3'h0, 8'h81, 1'h0, 1'h1}, '{1'h0, 3'h3, 8'h80, 1'h0, 1'h1},
    '{1'h0, 3'h1, 8'h01, 1'h0, 1'h1}, '{1'h1, 3'h0, 8'h00, 1'h0, 1'h1},
    '{1'h0, 3'h0, 8'h81, 1'h0, 1'h1}, '{1'h1, 3'h3, 8'h40, 1'h1, 1'h1},
    '{1'h1, 3'h3, 8'hc0, 1'h0, 1'h1}, '{1'h1, 3'h3, 8'h40, 1'h1, 1'h1},
    '{1'h0, 3'h3, 8'h40, 1'h1, 1'h1}, '{1'h1, 3'h0, 8'h00, 1'h1, 1'h0},
    '{1'h1, 3'h0, 8'h01, 1'h1, 1'h1}, '{1'h1, 3'h0, 8'h00, 1'h1, 1'h0},
    '{1'h1, 3'h1, 8'ha1, 1'h1, 1'h0}, '{1'h0, 3'h1, 8'ha1, 1'h1, 1'h0},
    '{1'h1, 3'h5, 8'hff, 1'h1, 1'h0}, '{1'h0, 3'h5, 8'h00, 1'h1, 1'h0}};

  loop_iface_init u_dut (.clk, .rstn, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .phi1, .phi2, .syncLine, .powerOnLevel, .dataIn, .dataOut,
    .dataOe, .instructionLineIn, .instructionLineOut, .instructionLineOe,
    .flagReturnOut, .flagReturnOe, .controllerStrap, .useTestClock,
    .testClockInput, .tankIn, .loopClock, .ifcEvent, .srqEvent,
    .frameWaitEvent, .frameMismatchEvent, .outRegTaken, .rtsEvent,
    .oscRunEnable, .masterClear, .requestToSend, .driverIdle,
    .acceptorIdle);

  cpu_bus_model u_cpu (.clk, .rstn, .mode, .nextInsn, .dataOut, .dataOe,
    .isaOut(instructionLineOut), .isaOe(instructionLineOe),
    .flagOut(flagReturnOut), .flagOe(flagReturnOe), .phi1, .phi2,
    .syncLine, .powerOnLevel, .dataLine(dataIn),
    .isaLine(instructionLineIn), .wordDone, .dataWord, .dataBits,
    .flagOeWord, .flagValWord);

  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // External loop clock replaces the tank, whose pin stays high.
  always @(posedge clk) testClockInput <= ~testClockInput;

  task check(input string what, input logic [55:0] got, exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task results();
    if (n_fail == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task wrReg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'h1;
    @(posedge clk);
    regWr    <= 1'h0;
  endtask

  task rdReg(input logic [2:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'h1;
    @(posedge clk);
    regRd   <= 1'h0;
    #1 rd = regRdata;
  endtask

  // Word ends are awaited under a bound so a stalled bus cannot hang us.
  task waitWord();
    int i;
    i = 0;
    do
    begin
      @(posedge clk);
      #1 i++;
    end
    while (!wordDone && i < 600);
    if (!wordDone)
    begin
      n_fail++;
      results();
    end
  endtask

  task word(input logic [9:0] insn);
    nextInsn <= insn;
    waitWord();
  endtask

  always @(posedge clk)
  begin
    if (rstn)
    begin
      check("data oe in phase two", dataOe && phi2, 1'h0);
      check("flag oe in phase two", flagReturnOe && phi2, 1'h0);
      check("isa oe in run", instructionLineOe && prevPwr && powerOnLevel,
            1'h0);
    end
    prevPwr  <= powerOnLevel;
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    waitWord();
    word(10'h0);
    check("flag oe after clear", flagOeWord, 56'h0);
    // Oscillator is enabled before master clear is lifted.
    foreach (rows[i])
    begin
      if (rows[i].wr)
        wrReg(rows[i].a, rows[i].d);
      else
        rdReg(rows[i].a);
      if (!rows[i].wr)
        check("register read", rd, rows[i].d);
      @(posedge clk);
      #1 check("osc enable", oscRunEnable, rows[i].osc);
      check("master clear", masterClear, rows[i].master_clear_bit);
    end
    waitWord();
    for (int k = 0; k < 5; k++)
    begin
      word(seq[k]);
      check("data bits", dataBits, (k == 2 || k == 3) ? 7'h38 : 7'h0);
      if (k == 2 || k == 3)
        check("data word", dataWord, 56'ha1);
    end
    check("flag digit oe", flagOeWord, 56'h000f0000000000);
    check("flag digit level", flagValWord & flagOeWord,
          56'h00080000000000);
    @(posedge clk);
    ifcEvent <= 1'h1;
    srqEvent <= 1'h1;
    frameMismatchEvent <= 1'h1;
    @(posedge clk);
    ifcEvent <= 1'h0;
    srqEvent <= 1'h0;
    frameMismatchEvent <= 1'h0;
    waitWord();
    word(10'h0);
    check("flag digits oe", flagOeWord, 56'h000ff0ff000000);
    check("flag digits level", flagValWord & flagOeWord,
          56'h00088088000000);
    mode <= 2'h1;
    repeat (4) @(posedge clk);
    #1 check("wake drive", {instructionLineOe, instructionLineOut}, 2'h3);
    check("light sleep kept", oscRunEnable, 1'h1);
    mode <= 2'h0;
    controllerStrap <= 1'h1;
    wrReg(3'h2, 8'h5a);
    @(posedge clk);
    rtsEvent <= 1'h1;
    frameWaitEvent <= 1'h1;
    @(posedge clk);
    rtsEvent <= 1'h0;
    frameWaitEvent <= 1'h0;
    repeat (2) @(posedge clk);
    #1 check("busy", {requestToSend, driverIdle, acceptorIdle}, 3'h4);
    mode <= 2'h2;
    repeat (8) @(posedge clk);
    #1 check("deep sleep", {oscRunEnable, masterClear, requestToSend,
          driverIdle, acceptorIdle}, 5'h0b);
    mode <= 2'h0;
    rdReg(3'h1);
    check("flags cleared", rd[4:0], 5'h01);
    rdReg(3'h0);
    check("controller bit", rd, 8'h01);
    rdReg(3'h3);
    check("auto idle kept", rd, 8'hc0);
    wrReg(3'h3, 8'h00);
    n = 0;
    repeat (32) @(posedge clk) if (loopClock === 1'h1) n++;
    check("loop clock runs", n > 0, 1'h1);
    mode <= 2'h1;
    repeat (8) @(posedge clk);
    #1 check("idle sleep reset", {oscRunEnable, masterClear}, 2'h1);
    n = 0;
    repeat (32) @(posedge clk) if (loopClock === 1'h1) n++;
    check("loop clock stops", n == 0, 1'h1);
    results();
  end
endmodule
